// *** logic/cspt_core.sv ***
// core peripheral register space, dual data pointers, stack and timing
// Function
// [R1] one machine cycle lasts exactly one oscillator clock
// [R2] no dummy cycles: every busy cycle fetches or executes
// [R3] timers advance every 12 clocks after reset, each selectable per clock
// [R4] an instruction takes one cycle per byte plus one execute cycle; the code gives a 3-byte instruction three cycles, not four
// [R5] external data move takes two cycles, direct-to-direct move three
// [R6] bit and byte operations change only their target, as legacy
// [R7] register space 80h-FFh reachable only by direct addressing
// [R8] registers with address low nibble 0h or 8h allow bit access
// [R9] two 16-bit data pointers; active one addresses external moves
// [R10] bit 0 of data_pointer_control selects the active pointer
// [R11] toggle enable bit 5 flips the selection after each external move
// [R12] auto update steps the active pointer up or down after a move
// [R13] stack pointer holds last used scratchpad location, freely loadable
// [R14] push increments then writes; pop reads then decrements
//
// The register addresses and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/100ps
module cspt_core import cspt_pkg::*; #(
	parameter int DIV = TIMER_DIV
) (
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic ins_valid_in,
	input wire logic [3:0] ins_op_in,
	input wire logic [1:0] ins_len_in,
	input wire logic [7:0] ins_addr_in,
	input wire logic [7:0] ins_src_in,
	input wire logic [2:0] ins_bit_in,
	input wire logic [7:0] ins_data_in,
	output logic ins_ready_out,
	output logic ins_done_out,
	output logic [7:0] ins_rdata_out,
	output logic [7:0] ram_addr_out,
	output logic ram_we_out,
	output logic [7:0] ram_wdata_out,
	input wire logic [7:0] ram_rdata_in,
	output logic [15:0] xaddr_out,
	output logic xrd_out,
	output logic xwr_out,
	output logic [7:0] xwdata_out,
	input wire logic [7:0] xrdata_in,
	output logic [NUM_TIMERS-1:0] timer_tick_out
);
	cspt_tick_if #(.N(NUM_TIMERS)) tk ();

	cspt_prescale #(.DIV(DIV), .N(NUM_TIMERS)) u_presc (
		.clk_sys_in(clk_sys_in),
		.nrst_in(nrst_in),
		.tk(tk)
	);

	// register state
	logic [7:0] sp_q;
	logic [7:0] sp_d;
	logic [15:0] dp_q [2];
	logic [15:0] dp_d [2];
	logic [7:0] dpc_q;
	logic [7:0] dpc_d;
	logic [7:0] tclk_q;
	logic [7:0] preg_q [128];
	logic err_q;
	logic [23:0] cyc_q;

	// sequencer state
	cspt_state_type st_q;
	logic [1:0] cnt_q;
	logic [3:0] op_q;
	logic [7:0] addr_q;
	logic [7:0] src_q;
	logic [2:0] bit_q;
	logic [7:0] data_q;
	logic [7:0] tmp_q;

	// bus state
	logic aw_hold_q;
	logic w_hold_q;
	logic [9:0] awidx_q;
	logic [7:0] wbyte_q;
	logic wlane_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;

	function automatic logic is_dedicated(input logic [7:0] a);
		is_dedicated = (a == PR_SP) || (a == PR_DPL) || (a == PR_DPH)
			|| (a == PR_DPL1) || (a == PR_DPH1) || (a == PR_DPC)
			|| (a == PR_TCLK);
	endfunction

	// register space read, shared by the bus and the core
	function automatic logic [7:0] preg_read(input logic [7:0] a);
		if (a == PR_SP)
			preg_read = sp_q;
		else if (a == PR_DPL)
			preg_read = dp_q[0][7:0];
		else if (a == PR_DPH)
			preg_read = dp_q[0][15:8];
		else if (a == PR_DPL1)
			preg_read = dp_q[1][7:0];
		else if (a == PR_DPH1)
			preg_read = dp_q[1][15:8];
		else if (a == PR_DPC)
			preg_read = dpc_q;
		else if (a == PR_TCLK)
			preg_read = tclk_q;
		else
			preg_read = preg_q[a[6:0]];
	endfunction

	function automatic logic [1:0] op_cycles(input logic [3:0] op,
		input logic [1:0] len);
		if (op == OP_XMOVE_RD || op == OP_XMOVE_WR)
			op_cycles = XMOVE_CYCLES; // [R5]
		else if (op == OP_MOV_DD)
			op_cycles = MOVDD_CYCLES; // [R5]
		else if (len == 2'h0 || len == 2'h3)
			op_cycles = 2'h3;
		else
			op_cycles = len + 2'h1; // [R4]
	endfunction

	// instruction port
	wire busy = (st_q == CSPT_BUSY);
	wire take = !busy && ins_valid_in;
	wire exec = busy && (cnt_q == 2'h0);
	wire [1:0] take_cnt = op_cycles(ins_op_in, ins_len_in) - 2'h1;
	assign ins_ready_out = !busy;

	// direct addresses at 80h and above go to registers, indirect never
	wire tgt_preg = addr_q[7]; // [R7]
	wire bitable = !tgt_preg || (addr_q[3:0] == 4'h0)
		|| (addr_q[3:0] == 4'h8); // [R8]
	wire [7:0] tgt_val = tgt_preg ? preg_read(addr_q) : ram_rdata_in;
	wire [7:0] src_val = src_q[7] ? preg_read(src_q) : ram_rdata_in;
	wire is_bitop = (op_q == OP_BIT_RD) || (op_q == OP_BIT_SET)
		|| (op_q == OP_BIT_CLR);
	wire bit_now = tgt_val[bit_q];

	// read-modify-write keeps every other bit untouched
	logic [7:0] bit_mask;
	logic [7:0] bit_val;
	assign bit_mask = 8'h01 << bit_q;
	assign bit_val = (op_q == OP_BIT_SET) ? (tgt_val | bit_mask)
		: (tgt_val & ~bit_mask); // [R6]

	wire set_clr = (op_q == OP_BIT_SET) || (op_q == OP_BIT_CLR);
	wire direct_wr = (op_q == OP_DIR_WR) || (op_q == OP_MOV_DD)
		|| (set_clr && bitable);
	logic [7:0] core_wval;
	assign core_wval = (op_q == OP_DIR_WR) ? data_q
		: (op_q == OP_MOV_DD) ? tmp_q
		: (op_q == OP_POP) ? ram_rdata_in : bit_val;

	wire core_preg_we = exec && tgt_preg
		&& (direct_wr || (op_q == OP_POP)); // [R7]
	wire [7:0] core_preg_a = addr_q;

	// scratchpad port; indirect access above 7Fh stays in scratchpad
	assign ram_we_out = exec && ((direct_wr && !tgt_preg)
		|| (op_q == OP_IND_WR) || (op_q == OP_PUSH)); // [R7]
	assign ram_wdata_out = ((op_q == OP_IND_WR) || (op_q == OP_PUSH))
		? data_q : core_wval;

	// external data move through the active pointer
	wire sel = dpc_q[DPC_SEL]; // [R10]
	assign xrd_out = exec && (op_q == OP_XMOVE_RD);
	assign xwr_out = exec && (op_q == OP_XMOVE_WR);
	assign xwdata_out = data_q;
	wire external_data_move_done = xrd_out || xwr_out;
	wire step_down = sel ? dpc_q[DPC_DIR1] : dpc_q[DPC_DIR0];
	wire [15:0] dp_step = step_down ? dp_q[sel] - 16'h0001
		: dp_q[sel] + 16'h0001;

	// bus decode
	wire [9:0] aw_idx = s_axi_awaddr[11:2];
	wire [9:0] ar_idx = s_axi_araddr[11:2];
	assign s_axi_awready = !aw_hold_q && !bvalid_q;
	assign s_axi_wready = !w_hold_q && !bvalid_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	wire wr_go = aw_hold_q && w_hold_q && !bvalid_q;
	wire aw_preg = (awidx_q[9:7] == 3'h1);
	wire ar_preg = (ar_idx[9:7] == 3'h1);
	wire ar_stat = (ar_idx == IDX_STATUS);
	wire aw_ok = aw_preg || (awidx_q == IDX_STATUS);
	wire bus_we = wr_go && aw_preg && wlane_q;
	wire [7:0] bus_a = {1'b1, awidx_q[6:0]};
	wire [31:0] ar_val = ar_preg ? {24'h000000, preg_read({1'b1, ar_idx[6:0]})}
		: {cyc_q, 7'h00, err_q};

	// byte write merge: core wins over the bus on the same location
	function automatic logic [7:0] merged(input logic [7:0] a,
		input logic [7:0] cur);
		merged = cur;
		if (bus_we && bus_a == a)
			merged = wbyte_q;
		if (core_preg_we && core_preg_a == a)
			merged = core_wval;
	endfunction

	always_comb begin
		sp_d = merged(PR_SP, sp_q); // [R13]
		dp_d[0] = {merged(PR_DPH, dp_q[0][15:8]),
			merged(PR_DPL, dp_q[0][7:0])};
		dp_d[1] = {merged(PR_DPH1, dp_q[1][15:8]),
			merged(PR_DPL1, dp_q[1][7:0])};
		dpc_d = merged(PR_DPC, dpc_q) & DPC_WMASK;
		if (exec && op_q == OP_PUSH)
			sp_d = sp_q + 8'h01; // [R14]
		if (exec && op_q == OP_POP)
			sp_d = sp_q - 8'h01; // [R14]
		if (external_data_move_done && dpc_q[DPC_STEP])
			dp_d[sel] = dp_step; // [R12]
		if (external_data_move_done && dpc_q[DPC_TOGGLE])
			dpc_d[DPC_SEL] = !sel; // [R11]
	end

	assign tk.fast = tclk_q[TCLK_FAST0 +: NUM_TIMERS]; // [R3]
	assign timer_tick_out = tk.tick;

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			sp_q <= SP_RST;
			dp_q[0] <= DP_RST;
			dp_q[1] <= DP_RST;
			dpc_q <= DPC_RST;
			tclk_q <= TCLK_RST;
		end else begin
			sp_q <= sp_d;
			dp_q[0] <= dp_d[0]; // [R9]
			dp_q[1] <= dp_d[1]; // [R9]
			dpc_q <= dpc_d;
			tclk_q <= merged(PR_TCLK, tclk_q) & TCLK_WMASK;
		end
	end

	// plain register space, only locations without dedicated logic
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			for (int i = 0; i < 128; i++)
				preg_q[i] <= PR_RST;
		end else if (core_preg_we && !is_dedicated(core_preg_a)) begin
			preg_q[core_preg_a[6:0]] <= core_wval;
		end else if (bus_we && !is_dedicated(bus_a)) begin
			preg_q[bus_a[6:0]] <= wbyte_q;
		end
	end

	// sequencer: one state step per clock, so one machine cycle per clock
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			st_q <= CSPT_IDLE;
			cnt_q <= 2'h0;
			op_q <= OP_NOP;
			addr_q <= 8'h00;
			src_q <= 8'h00;
			bit_q <= 3'h0;
			data_q <= 8'h00;
		end else if (take) begin
			st_q <= CSPT_BUSY;
			cnt_q <= take_cnt;
			op_q <= ins_op_in;
			addr_q <= ins_addr_in;
			src_q <= ins_src_in;
			bit_q <= ins_bit_in;
			data_q <= ins_data_in;
		end else if (busy) begin
			cnt_q <= cnt_q - 2'h1; // [R1]
			if (exec)
				st_q <= CSPT_IDLE; // [R2]
		end
	end

	// scratchpad address, source capture and pointer address latch
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ram_addr_out <= 8'h00;
			tmp_q <= 8'h00;
			xaddr_out <= 16'h0000;
		end else if (take) begin
			if (ins_op_in == OP_PUSH)
				ram_addr_out <= sp_d + 8'h01; // [R14]
			else if (ins_op_in == OP_POP)
				ram_addr_out <= sp_d; // [R14]
			else if (ins_op_in == OP_MOV_DD)
				ram_addr_out <= ins_src_in;
			else
				ram_addr_out <= ins_addr_in;
			xaddr_out <= dp_d[dpc_d[DPC_SEL]]; // [R9]
		end else if (busy && op_q == OP_MOV_DD && cnt_q == 2'h1) begin
			tmp_q <= src_val; // [R5]
			ram_addr_out <= addr_q;
		end
	end

	// results, cycle counter and refused bit access
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ins_done_out <= 1'b0;
			ins_rdata_out <= 8'h00;
			err_q <= 1'b0;
			cyc_q <= 24'h000000;
		end else begin
			ins_done_out <= exec;
			if (busy)
				cyc_q <= cyc_q + 24'h000001;
			if (exec && is_bitop)
				err_q <= !bitable; // [R8]
			if (exec && op_q == OP_DIR_RD)
				ins_rdata_out <= tgt_val;
			else if (exec && op_q == OP_BIT_RD)
				ins_rdata_out <= {7'h00, bit_now & bitable};
			else if (exec && (op_q == OP_IND_RD || op_q == OP_POP))
				ins_rdata_out <= ram_rdata_in;
			else if (xrd_out)
				ins_rdata_out <= xrdata_in;
		end
	end

	// bus write channel: address and data held until both are in
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			awidx_q <= 10'h000;
			wbyte_q <= 8'h00;
			wlane_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_q <= 1'b1;
				awidx_q <= aw_idx;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_q <= 1'b1;
				wbyte_q <= s_axi_wdata[7:0];
				wlane_q <= s_axi_wstrb[0];
			end
			if (wr_go) begin
				aw_hold_q <= 1'b0;
				w_hold_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= aw_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// bus read channel: answer one cycle after the address
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_q <= 1'b1;
			rdata_q <= (ar_preg || ar_stat) ? ar_val : 32'h00000000;
			rresp_q <= (ar_preg || ar_stat) ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end
endmodule

// *** logic/cspt_pkg.sv ***
// shared constants and types of the core pointer and timing block
package cspt_pkg;
	// peripheral register addresses
	localparam logic [7:0] PR_BASE = 8'h80;
	localparam logic [7:0] PR_SP = 8'h81;
	localparam logic [7:0] PR_DPL = 8'h82;
	localparam logic [7:0] PR_DPH = 8'h83;
	localparam logic [7:0] PR_DPL1 = 8'h84;
	localparam logic [7:0] PR_DPH1 = 8'h85;
	localparam logic [7:0] PR_DPC = 8'h86;
	localparam logic [7:0] PR_TCLK = 8'h8E;
	// data_pointer_control fields
	localparam int DPC_SEL = 0;
	localparam int DPC_STEP = 4;
	localparam int DPC_TOGGLE = 5;
	localparam int DPC_DIR0 = 6;
	localparam int DPC_DIR1 = 7;
	localparam logic [7:0] DPC_WMASK = 8'hF1;
	// timer clock control: bit TCLK_FAST0 + n makes timer n fast
	localparam int TCLK_FAST0 = 3;
	localparam logic [7:0] TCLK_WMASK = 8'h38;
	// reset values
	localparam logic [7:0] SP_RST = 8'h07;
	localparam logic [7:0] DPC_RST = 8'h00;
	localparam logic [7:0] TCLK_RST = 8'h00;
	localparam logic [15:0] DP_RST = 16'h0000;
	localparam logic [7:0] PR_RST = 8'h00;
	// timing
	localparam int TIMER_DIV = 12;
	localparam int NUM_TIMERS = 3;
	localparam logic [1:0] XMOVE_CYCLES = 2'h2;
	localparam logic [1:0] MOVDD_CYCLES = 2'h3;
	// instruction kinds on the instruction port
	localparam logic [3:0] OP_DIR_RD = 4'h0;
	localparam logic [3:0] OP_DIR_WR = 4'h1;
	localparam logic [3:0] OP_BIT_RD = 4'h2;
	localparam logic [3:0] OP_BIT_SET = 4'h3;
	localparam logic [3:0] OP_BIT_CLR = 4'h4;
	localparam logic [3:0] OP_IND_RD = 4'h5;
	localparam logic [3:0] OP_IND_WR = 4'h6;
	localparam logic [3:0] OP_XMOVE_RD = 4'h7;
	localparam logic [3:0] OP_XMOVE_WR = 4'h8;
	localparam logic [3:0] OP_PUSH = 4'h9;
	localparam logic [3:0] OP_POP = 4'hA;
	localparam logic [3:0] OP_MOV_DD = 4'hB;
	localparam logic [3:0] OP_NOP = 4'hC;
	// bus map: byte address = 4 * index
	localparam logic [9:0] IDX_STATUS = 10'h000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic {CSPT_IDLE, CSPT_BUSY} cspt_state_type;
endpackage

// *** logic/cspt_prescale.sv ***
// timer advance prescaler: divide by DIV unless a timer is set fast
`timescale 1ns/100ps
module cspt_prescale import cspt_pkg::*; #(
	parameter int DIV = TIMER_DIV,
	parameter int N = NUM_TIMERS
) (
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	cspt_tick_if.presc tk
);
	localparam int CW = $clog2(DIV);
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);

	// checked while elaborating, so a bad divider never reaches a run
	if (DIV < 2 || N < 1) begin : g_bad_param
		$error("prescale needs DIV >= 2 and N >= 1");
	end

	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic slow_q;
	wire wrap = (cnt_q == LAST);

	assign cnt_d = wrap ? '0 : cnt_q + CW'(1);
	// slow pulse: one clock in DIV, the legacy-compatible default
	assign tk.tick = tk.fast | {N{slow_q}}; // [R3]

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cnt_q <= '0;
			slow_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			slow_q <= wrap;
		end
	end
endmodule

// *** logic/cspt_tick_if.sv ***
// timer rate selection and timer advance pulses
`timescale 1ns/100ps
interface cspt_tick_if #(parameter int N = 3);
	logic [N-1:0] fast;
	logic [N-1:0] tick;
	modport core (output fast, input tick);
	modport presc (input fast, output tick);
endinterface

// *** tb/cspt_core_sva.sv ***
// assertions on the ports of the core pointer and timing block
`timescale 1ns/100ps
module cspt_core_sva import cspt_pkg::*; #(
	parameter int DIV = TIMER_DIV
) (
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic ins_valid_in,
	input wire logic [3:0] ins_op_in,
	input wire logic [1:0] ins_len_in,
	input wire logic ins_ready_out,
	input wire logic ins_done_out,
	input wire logic xrd_out,
	input wire logic xwr_out,
	input wire logic [NUM_TIMERS-1:0] timer_tick_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!nrst_in);
	// timer 0 is never sped up by the bench, so its gap must stay DIV
	logic [7:0] gap_q;
	logic seen_q;
	wire logic take = ins_valid_in && ins_ready_out;
	wire logic tk0 = timer_tick_out[0];
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			gap_q <= 8'h00;
			seen_q <= 1'b0;
		end else begin
			gap_q <= tk0 ? 8'h00 : gap_q + 8'h01;
			seen_q <= seen_q || tk0;
		end
	end
	a_ext_read: assert property (
		take && ins_op_in == OP_XMOVE_RD |-> ##2 xrd_out ##1 ins_done_out)
		else $error("external read timing");
	a_ext_write: assert property (
		take && ins_op_in == OP_XMOVE_WR |-> ##2 xwr_out ##1 ins_done_out)
		else $error("external write timing");
	a_move_three: assert property (
		take && ins_op_in == OP_MOV_DD |->
		##1 (!ins_done_out)[*3] ##1 ins_done_out)
		else $error("direct move timing");
	a_byte_cycles: assert property (
		take && ins_op_in == OP_NOP && ins_len_in == 2'h2 |->
		##1 (!ins_ready_out)[*3] ##1 ins_done_out)
		else $error("two byte instruction timing");
	a_strobe_pulse: assert property (
		xrd_out || xwr_out |=> !xrd_out && !xwr_out)
		else $error("external strobe too long");
	a_tick_gap: assert property (tk0 && seen_q |-> gap_q == DIV - 1)
		else $error("timer 0 advance period");
	a_tick_late: assert property (seen_q |-> gap_q < DIV)
		else $error("timer 0 advance missing");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid) else $error("read answer late");
	a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data lost");
	c_push: cover property (take && ins_op_in == OP_PUSH);
	c_ext: cover property (xrd_out);
	c_tick: cover property (tk0 && seen_q);
endmodule

bind cspt_core cspt_core_sva #(.DIV(DIV)) u_sva (
	.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .ins_valid_in(ins_valid_in),
	.ins_op_in(ins_op_in), .ins_len_in(ins_len_in),
	.ins_ready_out(ins_ready_out), .ins_done_out(ins_done_out),
	.xrd_out(xrd_out), .xwr_out(xwr_out), .timer_tick_out(timer_tick_out)
);

// *** tb/testbench.sv ***
// self-checking bench of the core pointer and timing block
`timescale 1ns/100ps
module testbench import cspt_pkg::*; ;
	localparam int TDIV = 4;
	logic clk_sys_in, nrst_in, awv, wv, bre, arv, rre, iv, awr, wrd, bv;
	logic arr, rv, idn, we, xrd, xwr;
	logic [11:0] awa, ara;
	logic [31:0] wd, rdd, d;
	logic [1:0] br, rr, len, r;
	logic [3:0] op;
	logic [7:0] ia, isrc, id, ird, ra, rwd, xwd;
	logic [7:0] ram [256];
	logic [2:0] ib;
	logic [15:0] xa, xs;
	logic [NUM_TIMERS-1:0] tick;
	int num_errors, samples_checked, cyc;
	wire logic [7:0] rdat = ram[ra];
	cspt_core #(.DIV(TDIV)) dut (
		.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
		.s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv),
		.s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdd), .s_axi_rresp(rr),
		.s_axi_rvalid(rv), .s_axi_rready(rre), .ins_valid_in(iv),
		.ins_op_in(op), .ins_len_in(len), .ins_addr_in(ia),
		.ins_src_in(isrc), .ins_bit_in(ib), .ins_data_in(id),
		.ins_ready_out(), .ins_done_out(idn), .ins_rdata_out(ird),
		.ram_addr_out(ra), .ram_we_out(we), .ram_wdata_out(rwd),
		.ram_rdata_in(rdat), .xaddr_out(xa), .xrd_out(xrd),
		.xwr_out(xwr), .xwdata_out(xwd), .xrdata_in(8'hC3),
		.timer_tick_out(tick)
	);
	initial begin
		clk_sys_in = 1'b0;
		forever #25 clk_sys_in = ~clk_sys_in;
	end
	always @(posedge clk_sys_in)
		if (we) ram[ra] <= rwd;
	task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic bus_wr(logic [7:0] a, logic [7:0] v);
		bit pa, pw, ta, tw;
		@(posedge clk_sys_in);
		awa <= {2'h0, a, 2'h0};
		wd <= {24'h0, v};
		awv <= 1'b1;
		wv <= 1'b1;
		bre <= 1'b1;
		pa = 1'b1;
		pw = 1'b1;
		while (pa || pw) begin
			@(negedge clk_sys_in);
			ta = pa && awr;
			tw = pw && wrd;
			@(posedge clk_sys_in);
			if (ta) awv <= 1'b0;
			if (tw) wv <= 1'b0;
			pa = pa && !ta;
			pw = pw && !tw;
		end
		do @(negedge clk_sys_in); while (!bv);
		r = br;
		@(posedge clk_sys_in);
		bre <= 1'b0;
	endtask
	task automatic bus_rd(logic [7:0] a);
		@(posedge clk_sys_in);
		ara <= {2'h0, a, 2'h0};
		arv <= 1'b1;
		rre <= 1'b1;
		do @(negedge clk_sys_in); while (!arr);
		@(posedge clk_sys_in);
		arv <= 1'b0;
		do @(negedge clk_sys_in); while (!rv);
		d = rdd;
		r = rr;
		@(posedge clk_sys_in);
		rre <= 1'b0;
	endtask
	task automatic wreg(logic [7:0] a, logic [7:0] v);
		bus_wr(a, v);
		chk("write response", r, RESP_OKAY);
	endtask
	task automatic rchk(logic [7:0] a, logic [31:0] e);
		bus_rd(a);
		chk("register", d, e);
	endtask
	// the source field stays on the stack pointer for direct moves
	task automatic ins(logic [3:0] o, logic [7:0] a = 8'h00,
		logic [2:0] b = 3'h0, logic [7:0] v = 8'h00, logic [1:0] l = 2'h1);
		@(posedge clk_sys_in);
		op <= o;
		ia <= a;
		ib <= b;
		id <= v;
		len <= l;
		isrc <= PR_SP;
		iv <= 1'b1;
		@(posedge clk_sys_in);
		iv <= 1'b0;
		cyc = 0;
		xs = 'x;
		do begin
			@(negedge clk_sys_in);
			cyc++;
			if (xrd || xwr) xs = xa;
		end while (!idn);
	endtask
	task automatic xm(logic [3:0] o, logic [15:0] e);
		ins(o, 8'h00, 3'h0, 8'h77);
		chk("external address", xs, e);
		chk("external cycles", cyc, 3);
	endtask
	task automatic t_reset();
		rchk(PR_SP, {24'h0, SP_RST});
		rchk(PR_DPC, {24'h0, DPC_RST});
		rchk(PR_DPH1, {24'h0, DP_RST[15:8]});
		rchk(PR_TCLK, {24'h0, TCLK_RST});
		bus_rd(8'h10);
		chk("unmapped read", r, RESP_SLVERR);
		bus_wr(8'h10, 8'hAA);
		chk("unmapped write", r, RESP_SLVERR);
	endtask
	task automatic t_timing();
		ins(OP_NOP);
		chk("one byte cycles", cyc, 3);
		ins(OP_NOP, 8'h00, 3'h0, 8'h00, 2'h2);
		chk("two byte cycles", cyc, 4);
		ins(OP_MOV_DD, 8'hA0);
		chk("direct move cycles", cyc, 4);
		ins(OP_DIR_RD, 8'hA0);
		chk("direct move value", ird, {24'h0, SP_RST});
	endtask
	task automatic t_pointers();
		wreg(PR_DPL, 8'h34);
		wreg(PR_DPH, 8'h12);
		wreg(PR_DPL1, 8'hCD);
		wreg(PR_DPH1, 8'hAB);
		xm(OP_XMOVE_RD, 16'h1234);
		chk("external data", ird, 32'hC3);
		wreg(PR_DPC, 8'h01);
		xm(OP_XMOVE_WR, 16'hABCD);
		chk("external write data", xwd, 32'h77);
		wreg(PR_DPC, 8'h21);
		xm(OP_XMOVE_WR, 16'hABCD);
		xm(OP_XMOVE_RD, 16'h1234);
		rchk(PR_DPC, 32'h21);
		wreg(PR_DPC, 8'h10);
		xm(OP_XMOVE_RD, 16'h1234);
		xm(OP_XMOVE_RD, 16'h1235);
		wreg(PR_DPC, 8'h50);
		xm(OP_XMOVE_RD, 16'h1236);
		rchk(PR_DPL, 32'h35);
		wreg(PR_DPC, 8'hFF);
		rchk(PR_DPC, {24'h0, DPC_WMASK});
		wreg(PR_DPC, 8'h00);
	endtask
	task automatic t_bits();
		ins(OP_DIR_WR, 8'h90, 3'h0, 8'hFF);
		ins(OP_BIT_CLR, 8'h90, 3'h2);
		ins(OP_DIR_RD, 8'h90);
		chk("bit clear", ird, 32'hFB);
		ins(OP_BIT_SET, 8'h88, 3'h7);
		ins(OP_DIR_RD, 8'h88);
		chk("bit set", ird, 32'h80);
		ins(OP_BIT_SET, 8'h89, 3'h0);
		ins(OP_DIR_RD, 8'h89);
		chk("refused bit set", ird, 32'h00);
		bus_rd(8'h00);
		chk("refused flag", d[0], 1'b1);
		ins(OP_IND_WR, PR_SP, 3'h0, 8'h55);
		chk("indirect write", ram[PR_SP], 32'h55);
		rchk(PR_SP, {24'h0, SP_RST});
		ins(OP_IND_RD, PR_SP);
		chk("indirect read", ird, 32'h55);
	endtask
	task automatic t_stack();
		wreg(PR_SP, 8'h30);
		ins(OP_PUSH, 8'h00, 3'h0, 8'h5A);
		chk("pushed byte", ram[8'h31], 32'h5A);
		rchk(PR_SP, 32'h31);
		ins(OP_POP, 8'h40);
		chk("popped byte", ird, 32'h5A);
		rchk(PR_SP, 32'h30);
	endtask
	task automatic t_timers();
		int n1, n2;
		wreg(PR_TCLK, 8'h20);
		n1 = 0;
		n2 = 0;
		repeat (8) begin
			@(negedge clk_sys_in);
			n1 += tick[1];
			n2 += tick[2];
		end
		chk("slow ticks", n1, 8 / TDIV);
		chk("fast ticks", n2, 8);
	endtask
	initial begin
		nrst_in = 1'b0;
		{awv, wv, bre, arv, rre, iv} = 6'h00;
		{awa, ara, wd} = 56'h0;
		{op, len, ia, isrc, ib, id} = 33'h0;
		num_errors = 0;
		samples_checked = 0;
		repeat (8) @(posedge clk_sys_in);
		nrst_in <= 1'b1;
		t_reset();
		t_timing();
		t_pointers();
		t_bits();
		t_stack();
		t_timers();
		test_done();
	end
	// the whole run needs well under a thousand cycles
	initial begin
		repeat (3000) @(posedge clk_sys_in);
		num_errors++;
		test_done();
	end
endmodule
